// *** test/lpcmd_host_model.sv ***
// Memory controller model driving select, clock-enable and command/address
`timescale 1ns/10ps
module lpcmd_host_model (
    input  wire logic  clock,
    output logic       cs_n,
    output logic       cke,
    output logic [9:0] ca_rise,
    output logic [9:0] ca_fall
);
    // Clock-enable held low through the ramp, device deselected
    initial begin
        cs_n    = 1'b1;
        cke     = 1'b0;
        ca_rise = 10'h155;
        ca_fall = 10'h2AA;
    end

    // Idle cycles with toggling address lines, clock-enable kept
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clock);
            cs_n    = 1'b1;
            ca_rise = ~ca_rise;
            ca_fall = ~ca_fall;
        end
    endtask

    // One command cycle, then a deselect cycle
    task automatic send(input logic sel_n, input logic ck, input logic [9:0] r,
                        input logic [9:0] f);
        @(negedge clock);
        cs_n    = sel_n;
        cke     = ck;
        ca_rise = r;
        ca_fall = f;
        idle(1);
    endtask
endmodule

// *** test/lpcmd_monitor.sv ***
// Checker of register reads, power states and init timing at the block ports
`timescale 1ns/10ps
module lpcmd_monitor
    import lpcmd_pkg::*;
#(
    parameter int INIT_CYCLES = AUTO_INIT_RUN
) (
    input wire logic          clock,
    input wire logic          resetn,
    input wire logic          cs_n,
    input wire logic          cke,
    input wire logic [9:0]    ca_rise,
    input wire logic [9:0]    ca_fall,
    input wire lpcmd_cmd_type cmd_out,
    input wire logic          cmd_valid,
    input wire logic          cmd_ready,
    input wire logic          mr_rvalid,
    input wire logic [7:0]    bank_open,
    input wire logic [2:0]    power_state,
    input wire logic          buffers_on,
    input wire logic          array_power_on,
    input wire logic          auto_init_status_bit
);
    localparam int BUSY_MAX = INIT_CYCLES + 4;
    logic cke_r;
    logic take;

    // Clock-enable of the previous edge, and a selected command edge
    always_ff @(posedge clock) begin
        cke_r <= cke;
    end
    assign take = !cs_n && cke && cke_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    mrd_answer_a: assert property (
        mr_rvalid |-> $past(take && ca_rise[3:0] == LPCMD_MRD, 2))
        else $error("register read answer without a read command");
    init_done_a: assert property (
        take && ca_rise == 10'h3F0 && ca_fall[1:0] == 2'b00 && auto_init_status_bit
        |-> ##[1:BUSY_MAX] !auto_init_status_bit)
        else $error("auto-init status did not clear in time");
    dpd_off_a: assert property (
        power_state == LP_DPD && $past(power_state) == LP_DPD |-> !array_power_on && !buffers_on)
        else $error("deep sleep left array power or buffers on");
    pd_off_a: assert property (
        (power_state == LP_PPD || power_state == LP_APD) && $stable(power_state) |-> !buffers_on)
        else $error("power-down left buffers on");
    apd_open_a: assert property (
        power_state == LP_APD && $stable(power_state) |-> bank_open != 8'h00)
        else $error("active power-down with all banks closed");
    idle_kind_a: assert property (
        (power_state == LP_PPD || power_state == LP_SREF) && $stable(power_state)
        |-> bank_open == 8'h00)
        else $error("precharge power-down or self-refresh with a bank open");
    exit_cke_a: assert property (
        $changed(power_state) && $past(power_state) inside {LP_PPD, LP_APD, LP_SREF, LP_DPD}
        |-> $past(cke) || $past(cke, 2))
        else $error("low-power state left without clock-enable high");
    entry_cke_a: assert property (
        $changed(power_state) && power_state inside {LP_PPD, LP_APD, LP_SREF, LP_DPD}
        |-> !$past(cke) || !$past(cke, 2))
        else $error("low-power state entered without clock-enable low");
    valid_cause_a: assert property (
        $rose(cmd_valid) |-> $past(!cs_n) || $past(!cs_n, 2))
        else $error("command word from a deselected cycle");
    word_hold_a: assert property (
        cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_out))
        else $error("command word changed while stalled");
endmodule

// *** test/tb.sv ***
// Testbench for the command, power and init block
`timescale 1ns/10ps
module tb;
    import lpcmd_pkg::*;
    logic          clock = 1'b0;
    logic          resetn = 1'b0;
    logic          cmd_ready = 1'b1;
    logic          cs_n, cke, cmd_valid, mr_rvalid, buffers_on, array_power_on;
    logic          dq_drive_en, burst_stop, auto_init_status_bit, cmd_error;
    logic [9:0]    ca_rise, ca_fall;
    logic [7:0]    mr_rdata, bank_open, rd;
    logic [2:0]    power_state;
    logic [3:0]    burst_len;
    lpcmd_cmd_type cmd_out;
    int            n_mismatch = 0;
    int            total_checks = 0;
    int            cycles = 0;

    always #25 clock = ~clock;

    lpcmd_host_model u_host (.clock(clock), .cs_n(cs_n), .cke(cke), .ca_rise(ca_rise),
        .ca_fall(ca_fall));
    lpcmd_ctrl #(.INIT_CYCLES(4)) u_lpcmd_ctrl (.clock(clock), .resetn(resetn),
        .cs_n(cs_n), .cke(cke), .ca_rise(ca_rise), .ca_fall(ca_fall), .cmd_out(cmd_out),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .mr_rdata(mr_rdata),
        .mr_rvalid(mr_rvalid), .bank_open(bank_open), .power_state(power_state),
        .buffers_on(buffers_on), .array_power_on(array_power_on), .dq_drive_en(dq_drive_en),
        .burst_len(burst_len), .burst_stop(burst_stop),
        .auto_init_status_bit(auto_init_status_bit), .cmd_error(cmd_error));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] pick(input int sel);
        case (sel)
            0: return {13'h0000, power_state};
            1: return {8'h00, bank_open};
            default: return {12'h000, burst_len};
        endcase
    endfunction

    // Poll a state output for a bounded time, then compare
    task automatic wait_eq(input int sel, input logic [15:0] exp);
        int i;
        for (i = 0; i < 16 && pick(sel) !== exp; i++) @(negedge clock);
        chk(pick(sel), exp);
    endtask

    task automatic mrd(input logic [7:0] a, output logic [7:0] d);
        int i;
        u_host.send(1'b0, 1'b1, {a[5:0], LPCMD_MRD}, {8'h00, a[7:6]});
        for (i = 0; i < 6 && mr_rvalid !== 1'b1; i++) @(negedge clock);
        chk(mr_rvalid, 1'b1);
        d = mr_rdata;
    endtask

    task automatic mwr(input logic [7:0] a, input logic [7:0] d);
        u_host.send(1'b0, 1'b1, {a[5:0], LPCMD_MWR}, {d, a[7:6]});
    endtask

    task automatic act(input logic [2:0] b);
        u_host.send(1'b0, 1'b1, {b, 5'h15, 2'b10}, 10'h1A5);
    endtask

    task automatic pre(input logic [2:0] b, input logic al);
        u_host.send(1'b0, 1'b1, {b, 2'b00, al, LPCMD_PRE}, 10'h000);
    endtask

    task automatic t_init;
        u_host.idle(6);
        chk(power_state, LP_BOOT);
        chk(auto_init_status_bit, 1'b1);
        u_host.send(1'b1, 1'b1, 10'h000, 10'h000);
        wait_eq(0, LP_INIT);
        mrd(MR_INFO, rd);
        chk(rd[0], 1'b1);
        mwr(MR_RESET, 8'h00);
        wait_eq(0, LP_IDLE);
        chk(auto_init_status_bit, 1'b0);
        mrd(MR_INFO, rd);
        chk(rd[0], 1'b0);
        $display("test init done");
    endtask

    task automatic t_banks;
        act(3'h5);
        wait_eq(1, 16'h0020);
        act(3'h2);
        wait_eq(1, 16'h0024);
        pre(3'h5, 1'b0);
        wait_eq(1, 16'h0004);
        act(3'h7);
        wait_eq(1, 16'h0084);
        pre(3'h5, 1'b1);
        wait_eq(1, 16'h0000);
        $display("test banks done");
    endtask

    task automatic t_power;
        act(3'h1);
        u_host.send(1'b1, 1'b0, 10'h000, 10'h000);
        wait_eq(0, LP_APD);
        chk(buffers_on, 1'b0);
        u_host.send(1'b1, 1'b1, 10'h000, 10'h000);
        wait_eq(0, LP_IDLE);
        chk(bank_open, 8'h02);
        pre(3'h0, 1'b1);
        wait_eq(1, 16'h0000);
        u_host.send(1'b1, 1'b0, 10'h000, 10'h000);
        wait_eq(0, LP_PPD);
        chk(buffers_on, 1'b0);
        u_host.send(1'b1, 1'b1, 10'h000, 10'h000);
        wait_eq(0, LP_IDLE);
        chk(buffers_on, 1'b1);
        u_host.send(1'b0, 1'b0, {6'h00, LPCMD_REFAB}, 10'h000);
        wait_eq(0, LP_SREF);
        u_host.send(1'b1, 1'b1, 10'h000, 10'h000);
        wait_eq(0, LP_IDLE);
        $display("test power done");
    endtask

    task automatic t_burst;
        int i;
        mwr(MR_FEAT1, 8'h04);
        wait_eq(2, 16'h0004);
        act(3'h0);
        u_host.send(1'b0, 1'b1, 10'h001, 10'h000);
        u_host.send(1'b0, 1'b1, {6'h00, LPCMD_TRM}, 10'h000);
        for (i = 0; i < 12 && burst_stop !== 1'b1; i++) @(negedge clock);
        chk(burst_stop, 1'b1);
        u_host.send(1'b0, 1'b1, 10'h005, 10'h001);
        wait_eq(1, 16'h0000);
        mwr(MR_FEAT1, 8'h02);
        wait_eq(2, 16'h0002);
        $display("test burst done");
    endtask

    task automatic t_buffer;
        cmd_ready = 1'b0;
        act(3'h3);
        u_host.send(1'b0, 1'b1, {3'h3, 6'h00, 1'b1}, 10'h000);
        u_host.send(1'b0, 1'b1, {3'h3, 6'h02, 1'b1}, 10'h000);
        chk(cmd_out.is_act, 1'b1);
        chk(cmd_out.bank, 3'h3);
        chk(cmd_out.row, 14'h35A5);
        cmd_ready = 1'b1;
        @(negedge clock);
        chk(cmd_out.is_write, 1'b1);
        @(negedge clock);
        chk(cmd_valid, 1'b0);
        pre(3'h3, 1'b1);
        wait_eq(1, 16'h0000);
        $display("test buffer done");
    endtask

    task automatic t_deep;
        u_host.send(1'b0, 1'b0, {6'h00, LPCMD_TRM}, 10'h000);
        wait_eq(0, LP_DPD);
        chk(array_power_on, 1'b0);
        chk(buffers_on, 1'b0);
        resetn = 1'b0;
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        chk(power_state, LP_BOOT);
        chk(array_power_on, 1'b1);
        chk(burst_len, 4'h2);
        chk(auto_init_status_bit, 1'b1);
        $display("test deep sleep done");
    endtask

    // Main sequence
    initial begin
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        t_init();
        t_banks();
        t_power();
        t_burst();
        t_buffer();
        t_deep();
        report_and_stop();
    end
endmodule

bind lpcmd_ctrl lpcmd_monitor #(.INIT_CYCLES(INIT_CYCLES)) u_lpcmd_monitor (
    .clock(clock), .resetn(resetn), .cs_n(cs_n), .cke(cke), .ca_rise(ca_rise),
    .ca_fall(ca_fall), .cmd_out(cmd_out), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .mr_rvalid(mr_rvalid), .bank_open(bank_open), .power_state(power_state),
    .buffers_on(buffers_on), .array_power_on(array_power_on),
    .auto_init_status_bit(auto_init_status_bit));

// *** verilog/lpcmd_buf.sv ***
// Two-entry valid/ready buffer for decoded command words
`timescale 1ns/10ps
module lpcmd_buf
    import lpcmd_pkg::*;
#(
    parameter int WIDTH = $bits(lpcmd_cmd_type)
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] mem_r [2];
    logic             wp_r;
    logic             rp_r;
    logic [1:0]       cnt_r;
    logic             push;
    logic             pop;

    initial begin
        if (WIDTH < 1) $error("lpcmd_buf width must be positive");
    end

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = (cnt_r != 2'd2);
    assign out_valid = (cnt_r != 2'd0);
    assign out_data  = mem_r[rp_r];

    // Storage and pointers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'd0;
        end else begin
            if (push) begin
                mem_r[wp_r] <= in_data;
                wp_r        <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// *** verilog/lpcmd_ctrl.sv ***
// Command decode, power-state control and auto-initialization for the DRAM die
`timescale 1ns/10ps
// Operation
// - Up to 256 byte-wide mode registers, read-only, write-only or read-write; here no register reads back a written value.
// - Self-refresh command with clock-enable falling enters self-refresh.
// - Activate decoded from first two rising bits; rest give row and bank.
// - Read/write decoded from first three rising bits; rest give start column.
// - Auto-close flag sampled on falling bit zero; closes bank after burst.
// - Precharge: all-bank flag set closes all banks, else only addressed bank.
// - Burst stop cuts a burst without auto-close at a prefetch boundary.
// - Power-down gates buffers and clock; precharge or active flavour by banks.
// - Deep sleep gates buffers, clock and array power; contents are lost.
// - Clock-enable rising exits low-power states; only idle or deselect then.
// - Idle command with select low, or select high, is a no-operation.
// - Self-refresh only from all idle; idle falling gives active or precharge PD.
// - Access is activate then read/write burst of length 4, 8 or 16.
// - Three bank bits pick one of eight banks; row bits 0..13 pick the row.
// - Clock-enable held low through ramp; outputs high-impedance while it is low.
// - Auto-init completes within 10 us of reset, then device is idle.
// - Register zero bit zero reads 1 while init runs, 0 when done.
module lpcmd_ctrl
    import lpcmd_pkg::*;
#(
    parameter int INIT_CYCLES = AUTO_INIT_RUN
) (
    input  wire logic                clock,
    input  wire logic                resetn,
    input  wire logic                cs_n,
    input  wire logic                cke,
    input  wire logic [9:0]          ca_rise,
    input  wire logic [9:0]          ca_fall,
    output lpcmd_cmd_type            cmd_out,
    output logic                     cmd_valid,
    input  wire logic                cmd_ready,
    output logic [7:0]               mr_rdata,
    output logic                     mr_rvalid,
    output logic [7:0]               bank_open,
    output logic [2:0]               power_state,
    output logic                     buffers_on,
    output logic                     array_power_on,
    output logic                     dq_drive_en,
    output logic [3:0]               burst_len,
    output logic                     burst_stop,
    output logic                     auto_init_status_bit,
    output logic                     cmd_error
);
    initial begin
        if (INIT_CYCLES < 1 || INIT_CYCLES > AUTO_INIT_CYCLES)
            $error("INIT_CYCLES must fit within the auto-init limit");
    end

    lpcmd_state_type state_r;
    lpcmd_state_type state_nxt;
    logic            cke_prev_r;
    logic [7:0]      open_r;
    logic [7:0]      mr1_r;
    logic [7:0]      mr2_r;
    logic [7:0]      mr3_r;
    logic [7:0]      mr_any_r [MR_COUNT];
    logic [15:0]     init_cnt_r;
    logic            busy_r;
    logic            burst_live_r;
    logic            burst_ap_r;
    logic [2:0]      burst_bank_r;
    logic [4:0]      beat_r;
    logic [7:0]      rdata_r;
    logic            rvalid_r;
    logic            stop_r;
    logic            err_r;
    lpcmd_cmd_type   dec;
    logic            dec_valid;
    logic            buf_ready;
    logic            sel;
    logic            cke_fall;
    logic            cke_rise;
    logic            is_idl;
    logic [3:0]      op4;
    logic            is_act;
    logic            is_rd;
    logic            is_wr;
    logic [4:0]      bl_beats;

    // Command classification
    assign sel      = !cs_n;
    assign op4      = ca_rise[3:0];
    assign cke_fall = cke_prev_r && !cke;
    assign cke_rise = !cke_prev_r && cke;
    assign is_idl   = !sel || (op4[2:0] == LPCMD_IDL[2:0]);
    assign is_act   = sel && (ca_rise[1:0] == 2'b10);
    assign is_wr    = sel && (ca_rise[2:0] == 3'b001);
    assign is_rd    = sel && (ca_rise[2:0] == 3'b101);

    // Burst length in beats from feature register one
    always_comb begin
        case (mr1_r[2:0])
            3'b011:  bl_beats = 5'd8;
            3'b100:  bl_beats = 5'd16;
            default: bl_beats = 5'd4;
        endcase
    end

    // Decoded command word for the datapath
    always_comb begin
        dec            = '0;
        dec.is_act     = is_act;
        dec.is_write   = is_wr;
        dec.is_read    = is_rd;
        dec.is_pre     = sel && (op4 == LPCMD_PRE);
        dec.is_trm     = sel && (op4 == LPCMD_TRM);
        dec.is_mwr     = sel && (op4 == LPCMD_MWR);
        dec.is_mrd     = sel && (op4 == LPCMD_MRD);
        dec.is_ref     = sel && (op4 == LPCMD_REFAB || op4 == LPCMD_REFPB);
        dec.bank       = ca_rise[9:7];
        // Row bits 12..8 ride the rising half; bits 7..0 and 13 the falling half
        dec.row        = {ca_fall[8], ca_rise[6:2], ca_fall[7:0]};
        // Column bit zero is never sent, so bursts start on an even column
        dec.col        = {ca_fall[6:1], ca_rise[6:5], 1'b0};
        dec.auto_close = ca_fall[CLS_BIT];
        dec.all_bank   = ca_rise[ALL_BIT];
        dec.mr_addr    = {ca_fall[1:0], ca_rise[9:4]};
        dec.mr_data    = ca_fall[9:2];
        // Row field only means something for an activate
        if (!is_act) begin
            dec.row = '0;
        end
        // Only stable clock-enable in idle hands a word to the user side
        dec_valid = cke && cke_prev_r && (state_r == LP_IDLE)
                    && !is_idl && !dec.is_ref;
    end

    // Power state transitions on clock-enable edges, and from init to idle when busy drops
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            LP_BOOT: begin
                if (cke_rise) state_nxt = LP_INIT;
            end
            LP_INIT: begin
                if (!busy_r) state_nxt = LP_IDLE;
                else if (cke_fall && is_idl) state_nxt = LP_PPD;
            end
            LP_IDLE: begin
                if (cke_fall && !burst_live_r) begin
                    if (sel && op4 == LPCMD_REFAB && open_r == 8'h00)
                        state_nxt = LP_SREF;
                    else if (sel && op4 == LPCMD_TRM)
                        state_nxt = LP_DPD;
                    else if (is_idl)
                        state_nxt = (open_r != 8'h00) ? LP_APD : LP_PPD;
                end
            end
            LP_PPD, LP_APD, LP_SREF: begin
                if (cke_rise && is_idl)
                    state_nxt = busy_r ? LP_INIT : LP_IDLE;
            end
            // Deep sleep lost everything, so leaving it restarts the boot flow
            LP_DPD: begin
                if (cke_rise && is_idl) state_nxt = LP_BOOT;
            end
            default: state_nxt = LP_BOOT;
        endcase
    end

    // State and clock-enable history
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_r    <= LP_BOOT;
            cke_prev_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cke_prev_r <= cke;
        end
    end

    // Auto-initialization after reset register write
    always_ff @(posedge clock) begin
        if (!resetn) begin
            busy_r     <= 1'b1;
            init_cnt_r <= 16'h0000;
        end else if (dec.is_mwr && cke && dec.mr_addr == MR_RESET
                     && (state_r == LP_INIT || state_r == LP_IDLE)) begin
            busy_r     <= 1'b1;
            init_cnt_r <= 16'(INIT_CYCLES);
        end else if (state_r == LP_BOOT) begin
            busy_r     <= 1'b1;
        end else if (init_cnt_r != 16'h0000) begin
            // Busy drops on the last count, ahead of the move to idle
            init_cnt_r <= init_cnt_r - 16'h0001;
            if (init_cnt_r == 16'h0001) busy_r <= 1'b0;
        end
    end

    // Open-bank tracking
    always_ff @(posedge clock) begin
        if (!resetn) begin
            open_r <= 8'h00;
        end else if (state_r == LP_BOOT || state_r == LP_DPD) begin
            open_r <= 8'h00;
        end else begin
            // Auto-close on the last beat pair; a new command in that cycle still lands
            if (burst_live_r && burst_ap_r && beat_r == 5'd2)
                open_r[burst_bank_r] <= 1'b0;
            if (dec_valid) begin
                if (is_act) open_r[dec.bank] <= 1'b1;
                if (dec.is_pre) begin
                    if (dec.all_bank) open_r <= 8'h00;
                    else open_r[dec.bank] <= 1'b0;
                end
            end
        end
    end

    // Burst progress, terminate and auto-close
    always_ff @(posedge clock) begin
        if (!resetn) begin
            burst_live_r <= 1'b0;
            burst_ap_r   <= 1'b0;
            burst_bank_r <= 3'd0;
            beat_r       <= 5'd0;
            stop_r       <= 1'b0;
        end else begin
            stop_r <= 1'b0;
            if (dec_valid && (is_rd || is_wr) && open_r[dec.bank]) begin
                burst_live_r <= 1'b1;
                burst_ap_r   <= dec.auto_close;
                burst_bank_r <= dec.bank;
                beat_r       <= bl_beats;
            end else if (dec_valid && dec.is_trm && burst_live_r && !burst_ap_r) begin
                burst_live_r <= 1'b0;
                beat_r       <= 5'd0;
                stop_r       <= 1'b1;
            end else if (burst_live_r) begin
                beat_r <= beat_r - 5'd2;
                if (beat_r <= 5'd2) burst_live_r <= 1'b0;
            end
        end
    end

    // Mode register file and read path
    always_ff @(posedge clock) begin
        if (!resetn) begin
            mr1_r    <= MR1_RESET;
            mr2_r    <= MR2_RESET;
            mr3_r    <= MR3_RESET;
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= 1'b0;
            // Configuration writes only in the idle state
            if (cke && cke_prev_r && dec.is_mwr && state_r == LP_IDLE) begin
                case (dec.mr_addr)
                    MR_FEAT1: mr1_r <= dec.mr_data;
                    8'h02:    mr2_r <= dec.mr_data;
                    8'h03:    mr3_r <= dec.mr_data;
                    default:  mr_any_r[dec.mr_addr] <= dec.mr_data;
                endcase
            end
            // Reads are also served while auto-init is still polled
            if (cke && cke_prev_r && dec.is_mrd
                && (state_r == LP_IDLE || state_r == LP_INIT)) begin
                rvalid_r <= 1'b1;
                case (dec.mr_addr)
                    MR_INFO: rdata_r <= {7'h00, busy_r};
                    8'h01, 8'h02, 8'h03, MR_RESET: rdata_r <= 8'h00; // Write-only
                    default: rdata_r <= 8'h00;
                endcase
            end
        end
    end

    // Illegal command sequence flag
    always_ff @(posedge clock) begin
        if (!resetn) begin
            err_r <= 1'b0;
        end else begin
            // Flags a command on an exit edge, a low-power entry mid-burst,
            // or anything but register access while auto-init runs
            err_r <= (cke_rise && !is_idl && state_r != LP_BOOT)
                  || (cke_fall && burst_live_r)
                  || (state_r == LP_INIT && cke && cke_prev_r && !is_idl
                      && !dec.is_mrd && !dec.is_mwr);
        end
    end

    // Registered status outputs
    always_ff @(posedge clock) begin
        if (!resetn) begin
            bank_open            <= 8'h00;
            power_state          <= LP_BOOT;
            buffers_on           <= 1'b0;
            array_power_on       <= 1'b1;
            dq_drive_en          <= 1'b0;
            burst_len            <= 4'h2;
            burst_stop           <= 1'b0;
            auto_init_status_bit <= 1'b1;
            mr_rdata             <= 8'h00;
            mr_rvalid            <= 1'b0;
            cmd_error            <= 1'b0;
        end else begin
            bank_open            <= open_r;
            power_state          <= state_r;
            buffers_on           <= (state_r == LP_IDLE || state_r == LP_INIT);
            array_power_on       <= (state_r != LP_DPD);
            dq_drive_en          <= cke && (burst_live_r || rvalid_r);
            burst_len            <= {1'b0, mr1_r[2:0]};
            burst_stop           <= stop_r;
            auto_init_status_bit <= busy_r;
            mr_rdata             <= rdata_r;
            mr_rvalid            <= rvalid_r;
            cmd_error            <= err_r;
        end
    end

    // Decoded commands pass through a two-entry buffer
    lpcmd_buf u_buf (
        .clock     (clock),
        .resetn    (resetn),
        .in_data   (dec),
        .in_valid  (dec_valid),
        .in_ready  (buf_ready),
        .out_data  (cmd_out),
        .out_valid (cmd_valid),
        .out_ready (cmd_ready)
    );
endmodule

// *** verilog/lpcmd_pkg.sv ***
// Package: constants and types for the command, power and init block
package lpcmd_pkg;

    // Command encodings on rising-edge bits ca[3:0] (bit0 first)
    localparam logic [3:0] LPCMD_MWR   = 4'h0;
    localparam logic [3:0] LPCMD_MRD   = 4'h8;
    localparam logic [3:0] LPCMD_REFPB = 4'h4;
    localparam logic [3:0] LPCMD_REFAB = 4'hC;
    localparam logic [3:0] LPCMD_PRE   = 4'hB;
    localparam logic [3:0] LPCMD_TRM   = 4'h3;
    localparam logic [3:0] LPCMD_IDL   = 4'h7;

    // Field positions
    localparam int ALL_BIT    = 4;
    localparam int CLS_BIT    = 0;
    localparam int NUM_BANKS  = 8;
    localparam int MR_COUNT   = 256;

    // Mode register addresses and reset values
    localparam logic [7:0] MR_INFO   = 8'h00;
    localparam logic [7:0] MR_FEAT1  = 8'h01;
    localparam logic [7:0] MR_RESET  = 8'h3F;
    localparam logic [7:0] MR1_RESET = 8'h22;
    localparam logic [7:0] MR2_RESET = 8'h01;
    localparam logic [7:0] MR3_RESET = 8'h02;

    // Timing, clock at 20 MHz
    localparam int CLK_PERIOD_NS    = 50;
    localparam int AUTO_INIT_MAX_US = 10;
    localparam int AUTO_INIT_CYCLES = (AUTO_INIT_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int AUTO_INIT_RUN    = AUTO_INIT_CYCLES / 2;

    // Power states
    typedef enum logic [2:0] {
        LP_BOOT  = 3'b000,
        LP_INIT  = 3'b001,
        LP_IDLE  = 3'b011,
        LP_PPD   = 3'b010,
        LP_APD   = 3'b110,
        LP_SREF  = 3'b111,
        LP_DPD   = 3'b101
    } lpcmd_state_type;

    // Decoded command word handed to the user side
    typedef struct packed {
        logic        is_write;
        logic        is_read;
        logic        is_act;
        logic        is_pre;
        logic        is_trm;
        logic        is_mrd;
        logic        is_mwr;
        logic        is_ref;
        logic        auto_close;
        logic        all_bank;
        logic [2:0]  bank;
        logic [13:0] row;
        logic [8:0]  col;
        logic [7:0]  mr_addr;
        logic [7:0]  mr_data;
    } lpcmd_cmd_type;

endpackage
